//--- rtl/dtm_pkg.sv
package dtm_pkg;

  // operating modes of the counter pair
  typedef enum logic [1:0] {
    DTM_DUAL8,
    DTM_CASC16,
    DTM_PULSE,
    DTM_PWM
  } dtm_mode_t;

  localparam int unsigned DTM_CNT_W      = 8;
  localparam int unsigned DTM_PRE_W      = 8;

  // register byte offsets
  localparam logic [7:0]  DTM_OFF_RUN    = 8'h00;
  localparam logic [7:0]  DTM_OFF_MODE   = 8'h04;
  localparam logic [7:0]  DTM_OFF_FFCTL  = 8'h08;
  localparam logic [7:0]  DTM_OFF_LOCMP  = 8'h0c;
  localparam logic [7:0]  DTM_OFF_UPCMP  = 8'h10;
  localparam logic [7:0]  DTM_OFF_STAT   = 8'h14;

  // field positions in the mode register
  localparam int unsigned DTM_MODE_LCS   = 0;
  localparam int unsigned DTM_MODE_UCS   = 2;
  localparam int unsigned DTM_MODE_PCS   = 4;
  localparam int unsigned DTM_MODE_PM    = 6;

  // field positions in the run, flip-flop control and status registers
  localparam int unsigned DTM_RUN_LO     = 0;
  localparam int unsigned DTM_RUN_UP     = 1;
  localparam int unsigned DTM_FF_SRC     = 0;
  localparam int unsigned DTM_FF_INV     = 1;
  localparam int unsigned DTM_FF_CLR     = 2;
  localparam int unsigned DTM_STAT_FF    = 16;

  // reset values
  localparam logic [7:0]  DTM_MODE_RST   = 8'h00;
  localparam logic [1:0]  DTM_FFCTL_RST  = 2'h0;
  localparam logic [7:0]  DTM_CMP_RST    = 8'hff;

  // pwm cycle lengths, in counts
  localparam logic [7:0]  DTM_PWM_P6     = 8'h3f;
  localparam logic [7:0]  DTM_PWM_P7     = 8'h7f;
  localparam logic [7:0]  DTM_PWM_P8     = 8'hff;

  // prescaler tap divide ratios as low-bit masks
  localparam logic [7:0]  DTM_TAP4_MASK  = 8'h03;
  localparam logic [7:0]  DTM_TAP16_MASK = 8'h0f;
  localparam logic [7:0]  DTM_TAP256_MASK = 8'hff;

endpackage

//--- rtl/dtm_prescaler.sv
`timescale 1ns/1ps
module dtm_prescaler (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  output logic      tap_div1,
  output logic      tap_div4,
  output logic      tap_div16,
  output logic      tap_div256
);
  import dtm_pkg::*;

  logic [DTM_PRE_W-1:0] pre_r;

  // free-running divider, held at zero while both run bits are clear so taps start aligned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= '0;
    end else if (run) begin
      pre_r <= pre_r + 1'b1;
    end else begin
      pre_r <= '0;
    end
  end

  // one-cycle enables, each on the last count of its period
  assign tap_div1   = run;
  assign tap_div4   = run && ((pre_r & DTM_TAP4_MASK) == DTM_TAP4_MASK);
  assign tap_div16  = run && ((pre_r & DTM_TAP16_MASK) == DTM_TAP16_MASK);
  assign tap_div256 = run && ((pre_r & DTM_TAP256_MASK) == DTM_TAP256_MASK);

endmodule

//--- rtl/dtm_timer_pair.sv
// Functional notes
// - mode field: 00 dual 8-bit, 01 cascaded 16-bit, 10 pulse generator, 11 pwm+timer.
// - lower clock select: 00 external, 01 div1, 10 div4, 11 div16, every mode.
// - dual mode upper clock: lower match, div1/16/256; source select picks flip-flop toggler.
// - 16-bit and pulse modes ignore cycle and upper clock selects; pulse ignores source.
// - pwm cycle 63, 127, 255 counts for codes 01..11; flip-flop carries pwm.
// - pwm mode: upper counter is an 8-bit timer on div1/16/256.
// - pwm mode: lower match is never a clock for the upper counter.
// - pwm mode: upper matches never reach the timer output.
`timescale 1ns/1ps
module dtm_timer_pair #(
  parameter int unsigned CNT_W = dtm_pkg::DTM_CNT_W
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_clk_in,
  output logic             timer_out,
  output logic             lower_match_pulse,
  output logic             upper_match_pulse
);
  import dtm_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // registers and state

  logic [1:0]       run_r;
  logic [7:0]       pair_mode_config_r;
  logic [1:0]       flipflop_control_r;
  logic [CNT_W-1:0] lo_cmp_r;
  logic [CNT_W-1:0] up_cmp_r;
  logic [CNT_W-1:0] lower_counter_r;
  logic [CNT_W-1:0] upper_counter_r;
  logic [2:0]       ext_sync_r;
  logic [31:0]      prdata_nxt;

  // selects one of four sources by a two-bit code
  function automatic logic pick4(input logic [1:0] code, input logic a, input logic b,
                                 input logic c, input logic d);
    pick4 = (code == 2'b00) ? a : (code == 2'b01) ? b : (code == 2'b10) ? c : d;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // apb decode

  wire setup_ph  = psel && !penable;
  wire access_ok = psel && penable && pready;
  wire wr_en     = access_ok && pwrite;
  wire hit_run   = (paddr == DTM_OFF_RUN);
  wire hit_mode  = (paddr == DTM_OFF_MODE);
  wire hit_ffctl = (paddr == DTM_OFF_FFCTL);
  wire hit_locmp = (paddr == DTM_OFF_LOCMP);
  wire hit_upcmp = (paddr == DTM_OFF_UPCMP);
  wire hit_stat  = (paddr == DTM_OFF_STAT);
  wire hit_any   = hit_run | hit_mode | hit_ffctl | hit_locmp | hit_upcmp | hit_stat;
  wire ff_clr    = wr_en && hit_ffctl && pwdata[DTM_FF_CLR];

  // read mux, captured in the setup cycle so the answer comes from flops
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    if (hit_run)   prdata_nxt[1:0] = run_r;
    if (hit_mode)  prdata_nxt[7:0] = pair_mode_config_r;
    if (hit_ffctl) prdata_nxt[1:0] = flipflop_control_r;
    if (hit_locmp) prdata_nxt[CNT_W-1:0] = lo_cmp_r;
    if (hit_upcmp) prdata_nxt[CNT_W-1:0] = up_cmp_r;
    if (hit_stat) begin
      prdata_nxt[CNT_W-1:0]         = lower_counter_r;
      prdata_nxt[2*CNT_W-1:CNT_W]   = upper_counter_r;
      prdata_nxt[DTM_STAT_FF]       = timer_out;
    end
  end

  // one wait-free access phase; unmapped addresses answer with an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph && !hit_any;
      prdata  <= setup_ph ? prdata_nxt : 32'h0000_0000;
    end
  end

  // configuration writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r              <= 2'b00;
      pair_mode_config_r <= DTM_MODE_RST;
      flipflop_control_r <= DTM_FFCTL_RST;
      lo_cmp_r           <= DTM_CMP_RST;
      up_cmp_r           <= DTM_CMP_RST;
    end else if (wr_en) begin
      if (hit_run)   run_r              <= pwdata[1:0];
      if (hit_mode)  pair_mode_config_r <= pwdata[7:0];
      if (hit_ffctl) flipflop_control_r <= pwdata[1:0];
      if (hit_locmp) lo_cmp_r           <= pwdata[CNT_W-1:0];
      if (hit_upcmp) up_cmp_r           <= pwdata[CNT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // field decode

  wire [1:0] pair_mode_field        = pair_mode_config_r[DTM_MODE_PM+:2];
  wire [1:0] pulse_cycle_select     = pair_mode_config_r[DTM_MODE_PCS+:2];
  wire [1:0] upper_clock_select     = pair_mode_config_r[DTM_MODE_UCS+:2];
  wire [1:0] lower_clock_select     = pair_mode_config_r[DTM_MODE_LCS+:2];
  wire       flipflop_source_select = flipflop_control_r[DTM_FF_SRC];
  wire       ff_invert_en           = flipflop_control_r[DTM_FF_INV];
  dtm_mode_t mode;
  assign mode = dtm_mode_t'(pair_mode_field);

  wire m_dual  = (mode == DTM_DUAL8);
  wire m_casc  = (mode == DTM_CASC16);
  wire m_pulse = (mode == DTM_PULSE);
  wire m_pwm   = (mode == DTM_PWM);

  // code 00 is undefined for the cycle field; treated as the longest cycle
  wire [CNT_W-1:0] pwm_len  = (pulse_cycle_select == 2'b01) ? DTM_PWM_P6 :
                              (pulse_cycle_select == 2'b10) ? DTM_PWM_P7 : DTM_PWM_P8;
  // a cycle of n counts ends on count n-1, as the counter starts from zero
  wire [CNT_W-1:0] pwm_last = pwm_len - 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // clock sources

  // external input is asynchronous: two flops, then edge detect on later stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sync_r <= 3'b000;
    end else begin
      ext_sync_r <= {ext_sync_r[1:0], ext_clk_in};
    end
  end
  wire ext_rise = ext_sync_r[1] && !ext_sync_r[2];

  logic t1, t4, t16, prescale_tap_div256;
  // taps faster than half the system clock are software's to avoid
  dtm_prescaler u_pre (
    .pclk       (pclk),
    .presetn    (presetn),
    .run        (|run_r),
    .tap_div1   (t1),
    .tap_div4   (t4),
    .tap_div16  (t16),
    .tap_div256 (prescale_tap_div256)
  );

  wire run_lo = run_r[DTM_RUN_LO];
  wire run_up = m_casc ? run_lo : run_r[DTM_RUN_UP];

  ////////////////////////////////////////////////////////////////////////
  // match detection and counter steps

  wire lo_tick  = run_lo && pick4(lower_clock_select, ext_rise, t1, t4, t16);
  wire lo_eq    = (lower_counter_r == lo_cmp_r);
  wire up_eq    = (upper_counter_r == up_cmp_r);
  wire lo_ovf   = lo_tick && (lower_counter_r == {CNT_W{1'b1}});
  wire match16  = lo_tick && lo_eq && up_eq;
  wire lo_match = lo_tick && lo_eq;

  // lower counter's last count per mode
  wire lo_end = m_dual  ? lo_eq :
                m_pulse ? (lower_counter_r == up_cmp_r) :
                m_pwm   ? (lower_counter_r == pwm_last) :
                          (lo_eq && up_eq);

  // upper clock: lower match only in dual mode, overflow when cascaded, none in pulse mode
  wire up_tap_tick = pick4(upper_clock_select, m_dual && lo_match, t1, t16, prescale_tap_div256);
  wire up_tick     = m_casc ? lo_ovf : (run_up && !m_pulse && up_tap_tick);
  // joint match needs no lower overflow, so any 16-bit compare value is reported
  wire up_match    = m_casc ? match16 : (up_tick && up_eq);

  // flip-flop toggle source per mode; upper timer only feeds it in dual mode
  wire ff_toggle = m_dual  ? (flipflop_source_select ? up_match : lo_match) :
                   m_casc  ? match16 :
                   lo_tick && (lo_eq || lo_end);

  // lower counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lower_counter_r <= '0;
    end else if (!run_lo) begin
      lower_counter_r <= '0;
    end else if (lo_tick) begin
      lower_counter_r <= lo_end ? '0 : lower_counter_r + 1'b1;
    end
  end

  // upper counter; in 16-bit mode it clears with the lower on the joint match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_counter_r <= '0;
    end else if (!run_up || m_pulse) begin
      upper_counter_r <= '0;
    end else if (m_casc && match16) begin
      upper_counter_r <= '0;
    end else if (up_tick) begin
      upper_counter_r <= (!m_casc && up_eq) ? '0 : upper_counter_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  // a toggle in the cycle of a software clear wins, so no edge is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_out         <= 1'b0;
      lower_match_pulse <= 1'b0;
      upper_match_pulse <= 1'b0;
    end else begin
      if (ff_invert_en && ff_toggle) begin
        timer_out <= !timer_out;
      end else if (ff_clr) begin
        timer_out <= 1'b0;
      end
      lower_match_pulse <= lo_tick && lo_end;
      upper_match_pulse <= up_match;
    end
  end

  // clock gear stays fixed while counting; nothing here guards against it

endmodule

//--- sim/dtm_timer_pair_assertions.sv
`timescale 1ns/1ps
module dtm_timer_pair_assertions
  import dtm_pkg::*;
#(
  parameter int unsigned CNT_W = DTM_CNT_W
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ext_clk_in,
  input wire logic        timer_out,
  input wire logic        lower_match_pulse,
  input wire logic        upper_match_pulse
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // the setup phase of a bus transfer, on any address and on a mapped address
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_mapped;
    s_setup ##0 (paddr <= DTM_OFF_STAT && paddr[1:0] == 2'h0);
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_ready_only_access: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held two cycles");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_err_unmapped: assert property (s_setup ##0 paddr > DTM_OFF_STAT |=> pready && pslverr)
    else $error("unmapped access not refused");
  a_ok_mapped: assert property (s_mapped |=> !pslverr)
    else $error("mapped access refused");
  a_reset_quiet: assert property ($rose(presetn) |-> !timer_out && !lower_match_pulse && !upper_match_pulse)
    else $error("timer outputs active after reset");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind dtm_timer_pair dtm_timer_pair_assertions #(.CNT_W(CNT_W)) dtm_timer_pair_assertions_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_clk_in(ext_clk_in),
  .timer_out(timer_out), .lower_match_pulse(lower_match_pulse), .upper_match_pulse(upper_match_pulse));

//--- sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import dtm_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, ext_clk_in, err;
  logic        pready, pslverr, timer_out, lower_match_pulse, upper_match_pulse;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          fail_count, checks_done, ec, p;
  dtm_timer_pair dtm_timer_pair_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clk_in(ext_clk_in), .timer_out(timer_out), .lower_match_pulse(lower_match_pulse),
    .upper_match_pulse(upper_match_pulse));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // external input: 3 clocks per level, above the 2-clock minimum
  always @(posedge pclk) begin
    ec         <= (ec == 5) ? 0 : ec + 1;
    ext_clk_in <= ec < 3;
  end
  task automatic print_verdict;
    if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic hang;
    fail_count++;
    print_verdict();
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // one bus transfer; request held until ready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready) break;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i == 20) hang();
    @(posedge pclk);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask
  task automatic cfg(input logic [7:0] m, input logic [2:0] f, input logic [7:0] lc, uc, input logic [1:0] r);
    xfer(1'b1, DTM_OFF_RUN, 32'h0);
    xfer(1'b1, DTM_OFF_MODE, {24'h0, m});
    xfer(1'b1, DTM_OFF_FFCTL, {29'h0, f});
    xfer(1'b1, DTM_OFF_LOCMP, {24'h0, lc});
    xfer(1'b1, DTM_OFF_UPCMP, {24'h0, uc});
    xfer(1'b1, DTM_OFF_RUN, {30'h0, r});
  endtask
  // cycles between 2nd and 3rd rising edge; first interval may hold start-up skew
  task automatic per(input int s, input int lim);
    int n, k, t0;
    logic v, pv;
    k = 0;
    pv = 1'b1;
    for (n = 0; n < lim; n++) begin
      @(posedge pclk);
      #1;
      v = (s == 0) ? lower_match_pulse : (s == 1) ? upper_match_pulse : timer_out;
      if (v === 1'b1 && pv !== 1'b1) k++;
      if (k == 2 && pv !== 1'b1 && v === 1'b1) t0 = n;
      if (k == 3) begin
        p = n - t0;
        @(posedge pclk);
        return;
      end
      pv = v;
    end
    hang();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rdc("run", DTM_OFF_RUN, 32'h0);
    rdc("mode", DTM_OFF_MODE, {24'h0, DTM_MODE_RST});
    rdc("locmp", DTM_OFF_LOCMP, {24'h0, DTM_CMP_RST});
    rdc("upcmp", DTM_OFF_UPCMP, {24'h0, DTM_CMP_RST});
    xfer(1'b1, DTM_OFF_STAT, 32'hffff);
    rdc("stat", DTM_OFF_STAT, 32'h0);
    xfer(1'b1, DTM_OFF_FFCTL, 32'h7);
    rdc("ffctl", DTM_OFF_FFCTL, 32'h3);
    rdc("unmapped", 8'h18, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
  endtask
  task automatic t_lower;
    int c;
    int dv[4] = '{6, 1, 4, 16};
    for (c = 0; c < 4; c++) begin
      cfg({6'h0, c[1:0]}, 3'h0, 8'h2, 8'hff, 2'b01);
      per(0, 400);
      chk("lower period", 32'(3 * dv[c]), 32'(p));
    end
  endtask
  task automatic t_upper;
    int c;
    int uv[4] = '{3, 1, 16, 256};
    for (c = 0; c < 4; c++) begin
      cfg({4'h0, c[1:0], 2'b01}, 3'h0, 8'h2, 8'h1, 2'b11);
      per(1, 2000);
      chk("upper period", 32'(2 * uv[c]), 32'(p));
    end
    cfg(8'h01, 3'h3, 8'h2, 8'h1, 2'b11);
    per(2, 200);
    chk("ff upper src", 32'd12, 32'(p));
    cfg(8'h01, 3'h2, 8'h2, 8'h1, 2'b11);
    per(2, 200);
    chk("ff lower src", 32'd6, 32'(p));
  endtask
  task automatic t_modes;
    int c, q, k;
    logic [7:0] pw[4] = '{DTM_PWM_P8, DTM_PWM_P6, DTM_PWM_P7, DTM_PWM_P8};
    cfg(8'h7d, 3'h2, 8'h4, 8'h1, 2'b01);
    per(1, 1000);
    chk("joint period", 32'd261, 32'(p));
    cfg(8'h81, 3'h2, 8'h2, 8'h7, 2'b01);
    per(2, 200);
    q = p;
    chk("pulse base", 32'd8, 32'(q));
    cfg(8'hbd, 3'h3, 8'h2, 8'h7, 2'b01);
    per(2, 200);
    chk("pulse period", 32'(q), 32'(p));
    for (c = 1; c < 4; c++) begin
      cfg({2'b11, c[1:0], 4'h5}, 3'h3, 8'h10, 8'h1, 2'b11);
      per(2, 1000);
      chk("pwm period", {24'h0, pw[c]}, 32'(p));
      per(1, 100);
      chk("spare period", 32'd2, 32'(p));
    end
    cfg(8'hd1, 3'h3, 8'h10, 8'h1, 2'b11);
    k = 0;
    repeat (300) begin
      @(posedge pclk);
      if (upper_match_pulse !== 1'b0) k++;
    end
    chk("spare idle", 32'h0, 32'(k));
    cfg(8'hd1, 3'h4, 8'h10, 8'h1, 2'b00);
    chk("ff cleared", 32'h0, {31'h0, timer_out});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_lower();
    t_upper();
    t_modes();
    print_verdict();
  end
endmodule
